// file: pdv_nv_store.sv
`default_nettype none
module pdv_nv_store
  import pdv_pkg::*;
#(
  parameter int unsigned DEPTH = NREG,
  parameter int unsigned WIDTH = 8,
  parameter int unsigned AW    = 3
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic             wr_en_i,
  input  wire logic [AW-1:0]    wr_idx_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic [AW-1:0]    rd_idx_i,
  output logic      [WIDTH-1:0] rd_data_o
);

  typedef logic [WIDTH-1:0] pdv_mem_t [DEPTH];

  // factory content as a declaration value, so only the write process drives the array
  function automatic pdv_mem_t factory_image();
    pdv_mem_t img;
    for (int i = 0; i < DEPTH; i++) begin
      img[i] = RST_IMAGE[i][WIDTH-1:0];
    end
    return img;
  endfunction : factory_image

  // the array is never touched by reset: it stands for the retained image
  pdv_mem_t mem = factory_image();

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_idx_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= mem[rd_idx_i];
    end
  end

endmodule : pdv_nv_store
`default_nettype wire

// file: pdv_pkg.sv
`default_nettype none
package pdv_pkg;

  // interfaces: shift-chain port, serial data port, fieldbus
  localparam int unsigned NIF          = 3;
  localparam int unsigned IF_SHIFT     = 0;
  localparam int unsigned IF_SERIAL    = 1;
  localparam int unsigned IF_FIELDBUS  = 2;

  // holding register addresses
  localparam logic [15:0] ADDR_SHIFT_VALID  = 16'h0022;
  localparam logic [15:0] ADDR_SERIAL_VALID = 16'h0023;
  localparam logic [15:0] ADDR_FBUS_VALID   = 16'h0024;
  localparam logic [15:0] ADDR_RESERVE_CFG  = 16'h0025;
  localparam logic [15:0] ADDR_RESERVE_CUR  = 16'h0026;
  localparam logic [15:0] ADDR_SCRIPT_EN    = 16'h0032;
  localparam logic [15:0] ADDR_SCRIPT_PORT  = 16'h0033;

  // slot of each register in the bank and in the nonvolatile image
  localparam int unsigned NREG          = 7;
  localparam logic [2:0]  IDX_SHIFT     = 3'h0;
  localparam logic [2:0]  IDX_SERIAL    = 3'h1;
  localparam logic [2:0]  IDX_FBUS      = 3'h2;
  localparam logic [2:0]  IDX_RSV_CFG   = 3'h3;
  localparam logic [2:0]  IDX_RSV_CUR   = 3'h4;
  localparam logic [2:0]  IDX_SCR_EN    = 3'h5;
  localparam logic [2:0]  IDX_SCR_PORT  = 3'h6;
  localparam logic [2:0]  IDX_LAST      = 3'h6;

  // values after reset, and the factory content of the nonvolatile image
  localparam logic [7:0] RST_VALID     = 8'h00;
  localparam logic [7:0] RST_RSV_CFG   = 8'h03;
  localparam logic [7:0] RST_RSV_CUR   = 8'h03;
  localparam logic [7:0] RST_SCR_EN    = 8'h00;
  localparam logic [7:0] RST_SCR_PORT  = 8'h01;
  localparam logic [NREG-1:0][7:0] RST_IMAGE = {RST_SCR_PORT, RST_SCR_EN, RST_RSV_CUR,
                                                RST_RSV_CFG, RST_VALID, RST_VALID,
                                                RST_VALID};

  // writable bits of the reservation and script-port slots
  localparam logic [7:0] MASK_RESERVE  = 8'h07;
  localparam logic [7:0] MASK_PORT     = 8'h03;

  // reservation field layout
  localparam int unsigned RSV_LED_BIT  = 0;
  localparam int unsigned RSV_IN_LSB   = 1;
  localparam logic [1:0]  RSV_IN_NONE  = 2'b00;
  localparam logic [1:0]  RSV_IN_ONE   = 2'b01;
  localparam logic [1:0]  RSV_IN_TWO   = 2'b10;

  // safe-value fields: shift chain bits 1:0, fieldbus 3:2, serial 5:4
  localparam int unsigned SAFE_LSB_SHIFT  = 0;
  localparam int unsigned SAFE_LSB_FBUS   = 2;
  localparam int unsigned SAFE_LSB_SERIAL = 4;
  localparam logic [1:0]  SAFE_ZERO       = 2'b00;
  localparam logic [1:0]  SAFE_ONE        = 2'b01;
  localparam logic [1:0]  SAFE_HOLD       = 2'b10;

  localparam logic [7:0]  SCRIPT_START    = 8'h01;

  // timebase
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned TICK_US        = 1000;
  localparam int unsigned TICK_CYCLES    = (CLK_HZ / 1_000_000) * TICK_US;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } pdv_reg_req_s;

  typedef struct packed {
    logic       led_out_en;
    logic [1:0] sw_in_bytes;
    logic [1:0] first_in_data_byte;
    logic       first_out_data_byte;
  } pdv_chain_s;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b01,
    ST_RUN  = 2'b10
  } pdv_state_e;

endpackage : pdv_pkg
`default_nettype wire

// file: pdv_producer.sv
`default_nettype none
module pdv_producer
  import pdv_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rstn_i,
  input  wire logic [NIF-1:0]      fire_i,
  output logic      [NIF-1:0]      produce_o,
  output logic      [NIF-1:0][7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // each production brings a fresh whole byte per interface
  always_ff @(posedge clk_i or negedge rstn_i) begin
    for (int g = 0; g < NIF; g++) begin
      if (!rstn_i) begin
        produce_o[g] <= 1'b0;
        data_o[g]    <= 8'h5A;
      end else begin
        produce_o[g] <= fire_i[g];
        if (fire_i[g]) begin
          data_o[g] <= data_o[g] + 8'h11;
        end
      end
    end
  end
endmodule : pdv_producer
`default_nettype wire

// file: pdv_validity_regs.sv
// Summary of operation
// - nonzero setting is timeout in milliseconds
// - zero setting disables timeout, data stays valid
// - expired timeout marks interface input invalid
// - invalid input forces routed outputs to safe value
// - three independent timeouts, one per interface
// - input field reserves zero, one or two bytes
// - bit zero reserves output byte 0 for LEDs
// - no reservation uses all bytes for data
// - assignment register reports active reservation
// - script enable: 0 stops, 1 starts
// - script port register selects script interface
// - safe field: zero, ones, or hold last
// - each chain module is one whole byte
`default_nettype none
module pdv_validity_regs
  import pdv_pkg::*;
#(
  parameter int unsigned MS_CYCLES = TICK_CYCLES,
  parameter int unsigned DW        = 8
) (
  input  wire logic                   clk_i,
  input  wire logic                   rstn_i,
  input  wire pdv_reg_req_s           req_i,
  output logic      [7:0]             rdata_o,
  output logic                        ack_o,
  output logic                        err_o,
  output logic                        busy_o,
  input  wire logic [NIF-1:0]         produce_i,
  input  wire logic [5:0]             safe_cfg_i,
  input  wire logic [NIF-1:0][DW-1:0] route_data_i,
  output logic      [NIF-1:0][DW-1:0] out_data_o,
  output logic      [NIF-1:0]         invalid_o,
  output pdv_chain_s                  chain_o,
  output logic                        script_run_o,
  output logic      [1:0]             script_port_o
);

  localparam int unsigned PW = $clog2(MS_CYCLES + 1);
  localparam logic [PW-1:0] MS_LAST = PW'(MS_CYCLES - 1);

  pdv_state_e       state;
  logic [2:0]       ld_cnt;
  logic [7:0]       cfg [NREG];
  logic [7:0]       nv_rd_data;
  logic [2:0]       nv_rd_idx;
  logic [2:0]       req_idx;
  logic             req_hit;
  logic             take_wr;
  logic             take_rd;
  logic [7:0]       wr_value;
  logic [1:0]       safe_sel [NIF];
  logic [7:0]       period [NIF];

  // address decode
  always_comb begin
    req_hit = 1'b1;
    req_idx = IDX_SHIFT;
    unique case (req_i.addr)
      ADDR_SHIFT_VALID:  req_idx = IDX_SHIFT;
      ADDR_SERIAL_VALID: req_idx = IDX_SERIAL;
      ADDR_FBUS_VALID:   req_idx = IDX_FBUS;
      ADDR_RESERVE_CFG:  req_idx = IDX_RSV_CFG;
      ADDR_RESERVE_CUR:  req_idx = IDX_RSV_CUR;
      ADDR_SCRIPT_EN:    req_idx = IDX_SCR_EN;
      ADDR_SCRIPT_PORT:  req_idx = IDX_SCR_PORT;
      default:           req_hit = 1'b0;
    endcase
  end

  // requests are held off while the image is being reloaded
  assign busy_o  = (state == ST_LOAD);
  assign take_wr = req_i.wr && !busy_o;
  assign take_rd = req_i.rd && !req_i.wr && !busy_o;

  // narrow registers keep only their defined bits
  always_comb begin
    wr_value = req_i.wdata;
    if (req_idx == IDX_RSV_CFG || req_idx == IDX_RSV_CUR) begin
      wr_value = req_i.wdata & MASK_RESERVE;
    end else if (req_idx == IDX_SCR_PORT) begin
      wr_value = req_i.wdata & MASK_PORT;
    end
  end

  // the count runs one past the last slot; keep the read inside the image
  assign nv_rd_idx = (ld_cnt < 3'(NREG)) ? ld_cnt : IDX_LAST;

  // every accepted write to a mapped address also lands in the retained image
  pdv_nv_store #(
    .DEPTH (NREG),
    .WIDTH (8),
    .AW    (3)
  ) u_nv (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .wr_en_i   (take_wr && req_hit),
    .wr_idx_i  (req_idx),
    .wr_data_i (wr_value),
    .rd_idx_i  (nv_rd_idx),
    .rd_data_o (nv_rd_data)
  );

  // reload sequencer: one slot per cycle, data one cycle behind the index
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state  <= ST_LOAD;
      ld_cnt <= 3'h0;
    end else begin
      unique case (state)
        ST_LOAD: begin
          if (ld_cnt == 3'(NREG)) begin
            state <= ST_RUN;
          end else begin
            ld_cnt <= ld_cnt + 3'h1;
          end
        end
        ST_RUN: begin
          ld_cnt <= ld_cnt;
        end
      endcase
    end
  end

  // register bank
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < NREG; i++) begin
        cfg[i] <= RST_IMAGE[i];
      end
    end else if (state == ST_LOAD) begin
      if (ld_cnt != 3'h0) begin
        cfg[ld_cnt - 3'h1] <= nv_rd_data;
      end
      // the stored configuration becomes the active assignment at start-up
      if (ld_cnt == 3'(NREG)) begin
        cfg[IDX_RSV_CUR] <= cfg[IDX_RSV_CFG];
      end
    end else if (take_wr && req_hit) begin
      cfg[req_idx] <= wr_value;
    end
  end

  // read data and access answer, one cycle after the request
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 8'h00;
      ack_o   <= 1'b0;
      err_o   <= 1'b0;
    end else begin
      ack_o <= take_wr || take_rd;
      err_o <= (take_wr || take_rd) && !req_hit;
      if (take_rd) begin
        rdata_o <= req_hit ? cfg[req_idx] : 8'h00;
      end
    end
  end

  // per-interface safe-value selection and period
  assign safe_sel[IF_SHIFT]    = safe_cfg_i[SAFE_LSB_SHIFT +: 2];
  assign safe_sel[IF_SERIAL]   = safe_cfg_i[SAFE_LSB_SERIAL +: 2];
  assign safe_sel[IF_FIELDBUS] = safe_cfg_i[SAFE_LSB_FBUS +: 2];
  assign period[IF_SHIFT]      = cfg[IDX_SHIFT];
  assign period[IF_SERIAL]     = cfg[IDX_SERIAL];
  assign period[IF_FIELDBUS]   = cfg[IDX_FBUS];

  generate
    for (genvar g = 0; g < NIF; g++) begin : g_if
      logic [PW-1:0] sub_cnt;
      logic [7:0]    ms_cnt;
      logic          ms_tick;
      logic          expire;

      assign ms_tick = (sub_cnt == MS_LAST);
      // the cycle prescaler restarts with each production, so the window is exact
      assign expire  = (period[g] != 8'h00) && ms_tick
                       && (ms_cnt + 8'h01 >= period[g]);

      // timer: restart on production, count whole milliseconds
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          sub_cnt <= '0;
          ms_cnt  <= 8'h00;
        end else if (produce_i[g] || period[g] == 8'h00 || invalid_o[g]) begin
          sub_cnt <= '0;
          ms_cnt  <= 8'h00;
        end else if (ms_tick) begin
          sub_cnt <= '0;
          ms_cnt  <= ms_cnt + 8'h01;
        end else begin
          sub_cnt <= sub_cnt + PW'(1);
        end
      end

      // a fresh production counts as arriving in time, even on the expiry cycle
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          invalid_o[g] <= 1'b0;
        end else if (produce_i[g] || period[g] == 8'h00 || state == ST_LOAD) begin
          invalid_o[g] <= 1'b0;
        end else if (expire) begin
          invalid_o[g] <= 1'b1;
        end
      end

      // routed output: live data, or the selected fallback while invalid
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          out_data_o[g] <= '0;
        end else if (!invalid_o[g]) begin
          out_data_o[g] <= route_data_i[g];
        end else begin
          unique case (safe_sel[g])
            SAFE_ZERO: out_data_o[g] <= '0;
            SAFE_ONE:  out_data_o[g] <= '1;
            SAFE_HOLD: out_data_o[g] <= out_data_o[g];
            default:   out_data_o[g] <= '0;
          endcase
        end
      end
    end
  endgenerate

  // chain byte assignment, from the active register, in whole 8-bit modules
  logic [1:0] in_field;
  assign in_field = cfg[IDX_RSV_CUR][RSV_IN_LSB +: 2];

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      chain_o <= '0;
    end else begin
      chain_o.led_out_en          <= cfg[IDX_RSV_CUR][RSV_LED_BIT];
      chain_o.first_out_data_byte <= cfg[IDX_RSV_CUR][RSV_LED_BIT];
      unique case (in_field)
        RSV_IN_ONE: begin
          chain_o.sw_in_bytes        <= 2'h1;
          chain_o.first_in_data_byte <= 2'h1;
        end
        RSV_IN_TWO: begin
          chain_o.sw_in_bytes        <= 2'h2;
          chain_o.first_in_data_byte <= 2'h2;
        end
        default: begin
          // 00, and the undefined code 11, leave every input byte for data
          chain_o.sw_in_bytes        <= 2'h0;
          chain_o.first_in_data_byte <= 2'h0;
        end
      endcase
    end
  end

  // script control; no run until the stored enable has been reloaded
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      script_run_o  <= 1'b0;
      script_port_o <= RST_SCR_PORT[1:0];
    end else begin
      script_run_o  <= (state == ST_RUN) && (cfg[IDX_SCR_EN] == SCRIPT_START);
      script_port_o <= cfg[IDX_SCR_PORT][1:0];
    end
  end

endmodule : pdv_validity_regs
`default_nettype wire

// file: pdv_validity_regs_bench.sv
`default_nettype none
module pdv_validity_regs_bench import pdv_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] RA [7] = '{16'h0022, 16'h0023, 16'h0024, 16'h0025, 16'h0026,
                                     16'h0032, 16'h0033};
  localparam logic [7:0]  RV [7] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h03, 8'h00, 8'h01};
  logic          clk_i  = 1'b0;
  logic          rstn_i = 1'b0;
  pdv_reg_req_s  req    = '0;
  logic [5:0]    safe   = 6'h18;
  logic [2:0]    fire   = 3'h0;
  logic [2:0]    prod, inv;
  logic [2:0][7:0] route, outd;
  logic [7:0]    rdata;
  logic          ack, err, busy, srun;
  logic [1:0]    sport;
  pdv_chain_s    ch;
  int            err_count = 0;
  int            compares  = 0;
  always #50 clk_i = ~clk_i;
  pdv_validity_regs #(.MS_CYCLES(4), .DW(8)) u_pdv_validity_regs (.clk_i(clk_i),
    .rstn_i(rstn_i), .req_i(req), .rdata_o(rdata), .ack_o(ack), .err_o(err), .busy_o(busy),
    .produce_i(prod), .safe_cfg_i(safe), .route_data_i(route), .out_data_o(outd),
    .invalid_o(inv), .chain_o(ch), .script_run_o(srun), .script_port_o(sport));
  pdv_producer u_pdv_producer (.clk_i(clk_i), .rstn_i(rstn_i), .fire_i(fire),
    .produce_o(prod), .data_o(route));
  task automatic chk_v(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_v
  task automatic chk_f(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_f
  task automatic results;
    $display("compares=%0d errors=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d, input logic e);
    @(posedge clk_i);
    req.wr <= w;
    req.rd <= !w;
    req.addr <= a;
    req.wdata <= d;
    @(posedge clk_i);
    req <= '0;
    #1;
    chk_f(ack, 1'b1);
    chk_f(err, e);
    if (!w) chk_v(rdata, d);
  endtask : xfer
  // a read issued during reload must vanish without an answer
  task automatic rst_cycle;
    int n;
    n = 0;
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    req.rd <= 1'b1;
    @(posedge clk_i);
    req <= '0;
    #1;
    chk_f(ack, 1'b0);
    do step(1); while (busy !== 1'b0 && ++n < 30);
    chk_f(busy, 1'b0);
  endtask : rst_cycle
  task automatic produce_all;
    @(posedge clk_i);
    fire <= 3'b111;
    @(posedge clk_i);
    fire <= 3'b000;
  endtask : produce_all
  initial begin
    logic [7:0] exp;
    rst_cycle();
    for (int i = 0; i < 7; i++) xfer(1'b0, RA[i], RV[i], 1'b0);
    xfer(1'b0, 16'h0027, 8'h00, 1'b1);
    xfer(1'b1, 16'h0031, 8'hFF, 1'b1);
    for (int i = 0; i < 3; i++) xfer(1'b1, RA[i], 8'(8'h11 * (i + 1)), 1'b0);
    xfer(1'b1, ADDR_RESERVE_CFG, 8'h05, 1'b0);
    xfer(1'b1, ADDR_RESERVE_CUR, 8'h00, 1'b0);
    rst_cycle();
    for (int i = 0; i < 3; i++) xfer(1'b0, RA[i], 8'(8'h11 * (i + 1)), 1'b0);
    xfer(1'b0, ADDR_RESERVE_CUR, 8'h05, 1'b0);
    step(2);
    chk_f(ch.led_out_en, 1'b1);
    chk_v({6'h00, ch.sw_in_bytes}, 8'h02);
    for (int c = 0; c < 8; c++) begin
      xfer(1'b1, ADDR_RESERVE_CUR, 8'(c), 1'b0);
      step(2);
      exp = (c[2:1] == 2'b01) ? 8'h01 : (c[2:1] == 2'b10) ? 8'h02 : 8'h00;
      chk_v({6'h00, ch.sw_in_bytes}, exp);
      chk_v({6'h00, ch.first_in_data_byte}, exp);
      chk_f(ch.led_out_en, c[0]);
      chk_f(ch.first_out_data_byte, c[0]);
      xfer(1'b0, ADDR_RESERVE_CUR, 8'(c), 1'b0);
    end
    xfer(1'b1, ADDR_SCRIPT_EN, 8'h01, 1'b0);
    step(2);
    chk_f(srun, 1'b1);
    xfer(1'b1, ADDR_SCRIPT_EN, 8'h00, 1'b0);
    xfer(1'b1, ADDR_SCRIPT_PORT, 8'h02, 1'b0);
    step(2);
    chk_f(srun, 1'b0);
    chk_v({6'h00, sport}, 8'h02);
    xfer(1'b1, ADDR_SHIFT_VALID, 8'h01, 1'b0);
    xfer(1'b1, ADDR_SERIAL_VALID, 8'h02, 1'b0);
    xfer(1'b1, ADDR_FBUS_VALID, 8'h00, 1'b0);
    produce_all();
    step(4);
    chk_v({5'h00, inv}, 8'h00);
    step(4);
    chk_v({5'h00, inv}, 8'h01);
    step(5);
    chk_v({5'h00, inv}, 8'h03);
    chk_v(outd[0], 8'h00);
    chk_v(outd[1], 8'hFF);
    chk_v(outd[2], 8'h6B);
    produce_all();
    step(4);
    chk_v({5'h00, inv}, 8'h00);
    chk_v(outd[0], 8'h7C);
    @(posedge clk_i);
    safe <= 6'h1A;
    step(6);
    chk_f(inv[0], 1'b1);
    chk_v(outd[0], 8'h7C);
    @(posedge clk_i);
    safe <= 6'h1B;
    step(2);
    chk_v(outd[0], 8'h00);
    results();
  end
  // whole sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk_i);
    err_count++;
    results();
  end
endmodule : pdv_validity_regs_bench
`default_nettype wire

// file: pdv_validity_regs_sva.sv
`default_nettype none
module pdv_validity_regs_sva
  import pdv_pkg::*;
#(
  parameter int unsigned MS_CYCLES = TICK_CYCLES,
  parameter int unsigned DW        = 8
) (
  input wire logic                   clk_i,
  input wire logic                   rstn_i,
  input wire pdv_reg_req_s           req_i,
  input wire logic [7:0]             rdata_o,
  input wire logic                   ack_o,
  input wire logic                   err_o,
  input wire logic                   busy_o,
  input wire logic [NIF-1:0]         produce_i,
  input wire logic [5:0]             safe_cfg_i,
  input wire logic [NIF-1:0][DW-1:0] route_data_i,
  input wire logic [NIF-1:0][DW-1:0] out_data_o,
  input wire logic [NIF-1:0]         invalid_o,
  input wire pdv_chain_s             chain_o,
  input wire logic                   script_run_o,
  input wire logic [1:0]             script_port_o
);
  timeunit 1ns;
  timeprecision 1ns;
  wire take = (req_i.wr | req_i.rd) & !busy_o;
  wire drop = (req_i.wr | req_i.rd) & busy_o;
  wire hit  = req_i.addr inside {[16'h0022:16'h0026], 16'h0032, 16'h0033};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_req_acked: assert property (take |=> ack_o) else $error("ack missing");
  a_ack_caused: assert property (ack_o |-> $past(take)) else $error("stray ack");
  a_busy_drops: assert property (drop |=> !ack_o) else $error("ack while busy");
  a_err_unmapped: assert property (take && !hit |=> ack_o && err_o)
    else $error("no error on unmapped");
  a_err_mapped: assert property (take && hit |=> !err_o) else $error("error on mapped");
  a_prod_clears: assert property (produce_i[0] |=> !invalid_o[0])
    else $error("production did not clear");
  a_safe_zero: assert property (invalid_o[0] && safe_cfg_i[1:0] == 2'b00 |=>
    out_data_o[0] == '0) else $error("zero fallback wrong");
  a_safe_ones: assert property (invalid_o[1] && safe_cfg_i[5:4] == 2'b01 |=>
    out_data_o[1] == '1) else $error("ones fallback wrong");
  a_valid_pass: assert property (!invalid_o[2] && !busy_o |=>
    out_data_o[2] == $past(route_data_i[2])) else $error("valid data not passed");
  a_chain_pair: assert property (chain_o.led_out_en == chain_o.first_out_data_byte &&
    chain_o.sw_in_bytes == chain_o.first_in_data_byte) else $error("chain fields disagree");
  c_expire: cover property ($rose(invalid_o[0]));
  c_err: cover property (err_o);
  c_script: cover property ($rose(script_run_o));
endmodule : pdv_validity_regs_sva
bind pdv_validity_regs pdv_validity_regs_sva #(.MS_CYCLES(MS_CYCLES), .DW(DW)) u_sva (.*);
`default_nettype wire
